// file: cdic_cpu_model.sv
`timescale 1ns/10ps
// ********************************************************************
// CPU sequencer model
// ********************************************************************
module cdic_cpu_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cpu_cycle_en,
  input wire logic [2:0] cmd,
  output logic sleep_instr,
  output logic interrupt_entry,
  output logic return_from_interrupt_instr
);
  logic [2:0] pend_q;
  logic [2:0] ev_q;
  // A request waits for a cycle in which the core may execute, because
  // the sequencer cannot retire an instruction while doze holds it off.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q <= 3'h0;
      ev_q <= 3'h0;
    end else begin
      ev_q <= (pend_q | cmd) & {3{cpu_cycle_en}};
      pend_q <= (pend_q | cmd) & ~{3{cpu_cycle_en}};
    end
  end
  // Each event leaves the model as a single-cycle pulse.
  assign sleep_instr = ev_q[0];
  assign interrupt_entry = ev_q[1];
  assign return_from_interrupt_instr = ev_q[2];
endmodule

// file: cdic_params.svh
// Operation
// - Idle select 1: sleep stops CPU clock, peripheral clocks keep running.
// - Idle select 0: sleep stops CPU and peripheral clocks (full sleep).
// - Doze enable 1: CPU executes cycles only at the doze ratio rate.
// - Doze enable 0: CPU executes every instruction cycle.
// - Recover-on-interrupt 1: interrupt entry clears doze enable.
// - Recover-on-interrupt 0: interrupt entry leaves doze enable alone.
// - Doze-on-exit 1: return from interrupt sets doze enable.
// - Doze-on-exit 0: return from interrupt leaves doze enable alone.
// - Ratio codes 000..111 select 1:2 up to 1:256.
// - In-circuit debug forces full speed without changing doze enable.
// - Idle select cleared only by POR/BOR; other bits cleared by any reset. The code keeps it only if psel is low at the first edge after a warm reset.
`ifndef CDIC_PARAMS_SVH
`define CDIC_PARAMS_SVH
// ****************************************************************
// Register map and field layout
// ****************************************************************
`define CDIC_ADDR_CTRL 12'h000
`define CDIC_BIT_IDLE 7
`define CDIC_BIT_DOZE_ENABLE 6
`define CDIC_BIT_ROI 5
`define CDIC_BIT_DOE 4
`define CDIC_RATIO_HI 2
`define CDIC_RATIO_LO 0
`define CDIC_WR_MASK 8'hF7
`define CDIC_RESET_VAL 8'h00
`define CDIC_CNT_ZERO 8'h00
`define CDIC_CNT_ONE 8'h01
`define CDIC_ZERO32 32'h00000000
`endif

// file: cdic_pkg.sv
package cdic_pkg;
  typedef enum logic [1:0] {
    CDIC_RUN = 2'b00,
    CDIC_IDLE = 2'b01,
    CDIC_SLEEP = 2'b10
  } cdic_mode_e;
  typedef struct packed {
    logic idle_select;
    logic doze_enable;
    logic recover_on_interrupt;
    logic doze_on_exit;
    logic [2:0] ratio;
    logic [7:0] cnt;
    cdic_mode_e mode;
    logic cpu_clk_en;
    logic periph_clk_en;
    logic cpu_cycle_en;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } cdic_state_s;
endpackage

// file: cdic_top.sv
`timescale 1ns/10ps
`include "cdic_params.svh"
module cdic_top
  import cdic_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic por_bor_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sleep_instr,
  input wire logic wake_event,
  input wire logic interrupt_entry,
  input wire logic return_from_interrupt_instr,
  input wire logic in_circuit_debug,
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic cpu_cycle_en
);
  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Terminal count of the doze counter: ratio 1:2^(code+1).
  // The 9-bit intermediate holds 256 for the largest code; the final
  // count always fits the 8-bit counter.
  function automatic logic [7:0] cdic_last(input logic [2:0] code);
    logic [8:0] full;
    full = 9'h002 << code;
    cdic_last = 8'(full - 9'h001);
  endfunction

  // Register image as software sees it.
  function automatic logic [7:0] cdic_pack(input cdic_state_s s);
    cdic_pack = {s.idle_select, s.doze_enable, s.recover_on_interrupt,
                 s.doze_on_exit, 1'b0, s.ratio};
  endfunction

  // Doze is live only while enabled and not masked by debug.
  function automatic logic cdic_live(input logic doze, input logic dbg);
    cdic_live = doze && !dbg;
  endfunction

  cdic_state_s s_q;
  cdic_state_s s_d;
  logic idle_keep_q;
  // Decode strobes and the live doze flag; wr_acc and hit are shared with the checks below.
  logic wr_acc;
  logic rd_acc;
  logic hit;
  logic doze_live;

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  // The bus answers in the access cycle with no wait states: the setup
  // cycle registers pready, read data and the error flag, so all three
  // come straight from flops and stand for exactly one cycle.
  // A write lands only at the edge where the master sees pready high,
  // which keeps the register and the handshake in step.
  always_comb begin
    s_d = s_q;
    // Address decode: only the control word is mapped.
    hit = (paddr == `CDIC_ADDR_CTRL);
    wr_acc = psel && penable && s_q.pready && pwrite;
    rd_acc = psel && !penable && !pwrite;
    // The answer is prepared in setup and shown in the access cycle.
    s_d.pready = psel && !penable;
    s_d.pslverr = psel && !penable && !hit;
    s_d.prdata = `CDIC_ZERO32;
    // Reads see the stored bits; bit 3 is packed as a constant zero.
    if (rd_acc && hit) begin
      s_d.prdata = {24'h000000, cdic_pack(s_q)};
    end
    // Only byte lane 0 holds the register; bit 3 is never stored.
    if (wr_acc && hit && pstrb[0]) begin
      s_d.idle_select = pwdata[`CDIC_BIT_IDLE];
      s_d.doze_enable = pwdata[`CDIC_BIT_DOZE_ENABLE];
      s_d.recover_on_interrupt = pwdata[`CDIC_BIT_ROI];
      s_d.doze_on_exit = pwdata[`CDIC_BIT_DOE];
      s_d.ratio = pwdata[`CDIC_RATIO_HI:`CDIC_RATIO_LO];
    end
    // Hardware events win over a software write in the same cycle.
    if (interrupt_entry && s_q.recover_on_interrupt) begin
      s_d.doze_enable = 1'b0;
    end else if (return_from_interrupt_instr && s_q.doze_on_exit) begin
      s_d.doze_enable = 1'b1;
    end
    // Debug masks doze without touching the stored bit.
    doze_live = cdic_live(s_q.doze_enable, in_circuit_debug);
    // The window counter runs from zero to the terminal count of the
    // ratio; holding it at zero while doze is off means the first cycle
    // after doze is entered always goes to the CPU.
    if (!doze_live || !s_q.cpu_clk_en) begin
      s_d.cnt = `CDIC_CNT_ZERO;
    end else if (s_q.cnt >= cdic_last(s_q.ratio)) begin
      s_d.cnt = `CDIC_CNT_ZERO;
    end else begin
      s_d.cnt = s_q.cnt + `CDIC_CNT_ONE;
    end
    // A sleep instruction chooses idle or full sleep from idle select.
    // Any wake event returns to run; its source is decided outside.
    case (s_q.mode)
      CDIC_RUN: begin
        if (sleep_instr) begin
          s_d.mode = s_q.idle_select ? CDIC_IDLE : CDIC_SLEEP;
        end
      end
      CDIC_IDLE, CDIC_SLEEP: begin
        if (wake_event) begin
          s_d.mode = CDIC_RUN;
        end
      end
      default: begin
        s_d.mode = CDIC_RUN;
      end
    endcase
    s_d.cpu_clk_en = (s_d.mode == CDIC_RUN);
    s_d.periph_clk_en = (s_d.mode != CDIC_SLEEP);
    // Only cycle zero of each doze window is given to the CPU.
    // Debug masks doze here too, so it forces full speed at once.
    s_d.cpu_cycle_en = s_d.cpu_clk_en &&
      (!cdic_live(s_d.doze_enable, in_circuit_debug) ||
       s_d.cnt == `CDIC_CNT_ZERO);
  end

  // ****************************************************************
  // State registers
  // ****************************************************************
  // Idle select is held across non-POR resets by a separate flop.
  // It stops following the register while presetn is low, otherwise
  // the cleared register would overwrite the copy during the reset.
  always_ff @(posedge pclk or negedge por_bor_n) begin
    if (!por_bor_n) begin
      idle_keep_q <= 1'b0;
    end else if (presetn) begin
      idle_keep_q <= s_d.idle_select;
    end
  end

  // Main state register. After a warm reset the idle select bit is put
  // back from the power-on copy only at the first edge, and only if psel is low
  // there, so that a restore never races a software write; later edges cannot restore it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.cpu_clk_en <= 1'b1;
      s_q.periph_clk_en <= 1'b1;
      s_q.cpu_cycle_en <= 1'b1;
    end else begin
      s_q <= s_d;
      if (!s_q.pready && !s_q.pslverr && s_q.mode == CDIC_RUN &&
          s_q.cnt == `CDIC_CNT_ZERO && !psel && !s_q.idle_select &&
          idle_keep_q) begin
        s_q.idle_select <= idle_keep_q;
      end
    end
  end

  // Every output is taken straight from the state flops.
  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign cpu_clk_en = s_q.cpu_clk_en;
  assign periph_clk_en = s_q.periph_clk_en;
  assign cpu_cycle_en = s_q.cpu_cycle_en;

  // ****************************************************************
  // Checks
  // ****************************************************************
  // Bus answers last one cycle and refusals carry no data.
  bus_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("pready stood for more than one cycle");

  // An error is only ever reported together with pready.
  err_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("pslverr without pready");

  // A refused address must read back as zero.
  err_data_a: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> (prdata == `CDIC_ZERO32))
    else $error("refused read returned data");

  // Only the low byte of the bus carries register bits.
  upper_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    pready |-> (prdata[31:8] == 24'h000000))
    else $error("upper read lanes not zero");

  // Bit 3 has no storage behind it, so it must never read as one.
  bit3_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    pready |-> !prdata[3])
    else $error("unimplemented bit read as one");

  // ****************************************************************
  // Clock gating checks
  // ****************************************************************
  // Idle stops only the core clock.
  idle_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.mode == CDIC_RUN && sleep_instr && s_q.idle_select)
    |=> (!cpu_clk_en && periph_clk_en))
    else $error("idle did not stop only the cpu clock");

  // Full sleep stops both clocks.
  full_sleep_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.mode == CDIC_RUN && sleep_instr && !s_q.idle_select)
    |=> (!cpu_clk_en && !periph_clk_en))
    else $error("full sleep did not stop both clocks");

  // The enables stay in step with the idle state throughout.
  idle_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.mode == CDIC_IDLE) |-> (!cpu_clk_en && periph_clk_en))
    else $error("idle state with wrong clock enables");

  // The enables stay in step with the full sleep state throughout.
  sleep_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.mode == CDIC_SLEEP) |-> (!cpu_clk_en && !periph_clk_en))
    else $error("sleep state with wrong clock enables");

  // A stopped core clock never grants an instruction cycle.
  stopped_core_a: assert property (@(posedge pclk) disable iff (!presetn)
    !cpu_clk_en |-> !cpu_cycle_en)
    else $error("cycle granted with core clock stopped");

  // A wake event brings both clocks back on the next cycle.
  wake_run_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.mode != CDIC_RUN && wake_event)
    |=> (cpu_clk_en && periph_clk_en))
    else $error("wake did not restart the clocks");

  // ****************************************************************
  // Doze checks
  // ****************************************************************
  // Without doze every running cycle goes to the core.
  full_speed_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!s_d.doze_enable && s_d.mode == CDIC_RUN) |=> cpu_cycle_en)
    else $error("cycle lost without doze");

  // The same seen from the stored bits.
  run_full_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.mode == CDIC_RUN && !s_q.doze_enable) |-> cpu_cycle_en)
    else $error("running without doze but cycle withheld");

  // A granted doze cycle is followed by a withheld one.
  doze_gap_a: assert property (@(posedge pclk) disable iff (!presetn)
    (cpu_cycle_en && s_q.doze_enable && !in_circuit_debug &&
     s_q.cnt == `CDIC_CNT_ZERO && s_q.mode == CDIC_RUN &&
     !interrupt_entry && !sleep_instr && !(wr_acc && hit))
    |=> !cpu_cycle_en)
    else $error("doze gave two cycles in a row");

  // The window counter restarts whenever doze is not live.
  count_restart_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!s_q.doze_enable || in_circuit_debug)
    |=> (s_q.cnt == `CDIC_CNT_ZERO))
    else $error("doze counter did not restart");

  // Interrupt entry clears doze when recovery is chosen.
  roi_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    (interrupt_entry && s_q.recover_on_interrupt) |=> !s_q.doze_enable)
    else $error("interrupt entry kept doze");

  // Interrupt entry leaves doze alone otherwise.
  roi_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    (interrupt_entry && !s_q.recover_on_interrupt &&
     !return_from_interrupt_instr && !(wr_acc && hit))
    |=> $stable(s_q.doze_enable))
    else $error("interrupt entry changed doze");

  // Return sets doze when doze on exit is chosen.
  doe_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    (return_from_interrupt_instr && s_q.doze_on_exit && !interrupt_entry)
    |=> s_q.doze_enable)
    else $error("return did not set doze");

  // Return leaves doze alone otherwise.
  doe_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    (return_from_interrupt_instr && !s_q.doze_on_exit &&
     !interrupt_entry && !(wr_acc && hit))
    |=> $stable(s_q.doze_enable))
    else $error("return changed doze");

  // Debug forces every running cycle through.
  debug_fast_a: assert property (@(posedge pclk) disable iff (!presetn)
    (in_circuit_debug && s_d.mode == CDIC_RUN) |=> cpu_cycle_en)
    else $error("debug did not force full speed");

  // Debug itself never touches the stored doze bit.
  debug_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    (in_circuit_debug && !interrupt_entry &&
     !return_from_interrupt_instr && !(wr_acc && hit))
    |=> $stable(s_q.doze_enable))
    else $error("debug changed the doze bit");
endmodule

// file: testbench.sv
`timescale 1ns/10ps
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin bad_count++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, s); end end
// ********************************************************************
// Bench
// ********************************************************************
module testbench;
  import cdic_pkg::*;
  typedef struct packed {
    logic [7:0] wd;
    logic [2:0] ev;
    logic dbg;
    logic [7:0] rv;
    logic [9:0] cnt;
    logic per;
  } cdic_row_s;
  logic pclk = 1'h0, presetn = 1'h0, por_bor_n = 1'h0, err;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, dbg = 1'h0;
  logic wake = 1'h0, pready, pslverr, sl, ie, ri, cclk, pclk_en, cyc;
  logic [2:0] cmd = 3'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  int checks = 0, bad_count = 0, n;
  // Command bits: 1 sleep, 2 interrupt entry, 4 return from interrupt.
  cdic_row_s rows [17] = '{
    '{8'h40, 3'h0, 1'h0, 8'h40, 256, 1'h1}, '{8'h41, 3'h0, 1'h0, 8'h41, 128, 1'h1},
    '{8'h42, 3'h0, 1'h0, 8'h42, 64, 1'h1}, '{8'h43, 3'h0, 1'h0, 8'h43, 32, 1'h1},
    '{8'h44, 3'h0, 1'h0, 8'h44, 16, 1'h1}, '{8'h45, 3'h0, 1'h0, 8'h45, 8, 1'h1},
    '{8'h46, 3'h0, 1'h0, 8'h46, 4, 1'h1}, '{8'h47, 3'h0, 1'h0, 8'h47, 2, 1'h1},
    '{8'h00, 3'h0, 1'h0, 8'h00, 512, 1'h1}, '{8'h60, 3'h2, 1'h0, 8'h20, 512, 1'h1},
    '{8'h40, 3'h2, 1'h0, 8'h40, 256, 1'h1}, '{8'h10, 3'h4, 1'h0, 8'h50, 256, 1'h1},
    '{8'h00, 3'h4, 1'h0, 8'h00, 512, 1'h1}, '{8'h47, 3'h0, 1'h1, 8'h47, 512, 1'h1},
    '{8'h80, 3'h1, 1'h0, 8'h80, 0, 1'h1}, '{8'h00, 3'h1, 1'h0, 8'h00, 0, 1'h0},
    '{8'h08, 3'h0, 1'h0, 8'h00, 512, 1'h1}};
  cdic_top i_dut (.pclk(pclk), .presetn(presetn), .por_bor_n(por_bor_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sleep_instr(sl), .wake_event(wake),
    .interrupt_entry(ie), .return_from_interrupt_instr(ri),
    .in_circuit_debug(dbg), .cpu_clk_en(cclk), .periph_clk_en(pclk_en),
    .cpu_cycle_en(cyc));
  cdic_cpu_model i_cpu (.pclk(pclk), .presetn(presetn), .cpu_cycle_en(cyc),
    .cmd(cmd), .sleep_instr(sl), .interrupt_entry(ie),
    .return_from_interrupt_instr(ri));
  always #12.5 pclk = ~pclk;
  // The request holds until pready is seen high at a rising edge; data is
  // taken at that edge and the request released right after it.
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    int t;
    t = 0;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1 && ++t < 20);
    if (t >= 20) bad_count++;
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // A cold reset also clears the power-on copy of the idle select bit.
  task automatic rst(input logic cold);
    @(posedge pclk);
    presetn <= 1'h0;
    por_bor_n <= ~cold;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    por_bor_n <= 1'h1;
    repeat (4) @(posedge pclk);
    apb(1'h0, 12'h000, 32'h0);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // The window of 512 cycles is a multiple of every doze period.
  initial begin
    rst(1'h1);
    `CHK("reset value", 32'h0, rd)
    apb(1'h0, 12'h004, 32'h0);
    `CHK("unmapped error", 1'h1, err)
    foreach (rows[i]) begin
      apb(1'h1, 12'h000, {24'h0, rows[i].wd});
      dbg <= rows[i].dbg;
      cmd <= rows[i].ev;
      @(posedge pclk);
      cmd <= 3'h0;
      repeat (4) @(posedge pclk);
      n = 0;
      repeat (512) begin
        @(negedge pclk);
        if ((cyc & cclk) === 1'h1) n++;
      end
      `CHK("cpu cycles", rows[i].cnt, n)
      `CHK("periph clock", rows[i].per, pclk_en)
      @(posedge pclk);
      wake <= 1'h1;
      @(posedge pclk);
      wake <= 1'h0;
      apb(1'h0, 12'h000, 32'h0);
      `CHK("register", rows[i].rv, rd[7:0])
      $display("row %0d done", i);
    end
    apb(1'h1, 12'h000, 32'hC5);
    rst(1'h0);
    `CHK("warm reset", 32'h80, rd)
    rst(1'h1);
    `CHK("cold reset", 32'h0, rd)
    $display("reset test done");
    print_verdict();
  end
  // The run needs about 9000 cycles; over twice that means a hang.
  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    print_verdict();
  end
endmodule
